// file: hw/led_sup_pkg.sv
package led_sup_pkg;
	// apb register map (byte addresses)
	localparam logic [11:0] CTRL_OFFSET      = 12'h000;
	localparam logic [11:0] STATUS_OFFSET    = 12'h004;
	localparam logic [11:0] INT_STAT_OFFSET  = 12'h008;
	localparam logic [11:0] INT_CLEAR_OFFSET = 12'h00c;
	localparam logic [11:0] INT_EN_OFFSET    = 12'h010;
	localparam logic [11:0] DITHER_OFFSET    = 12'h014;
	// ctrl fields
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_MASK_BIT     = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
	// interrupt event bits
	localparam int IRQ_LATCH_BIT   = 0;
	localparam int IRQ_FREQUENCY_SET_PIN_BIT    = 1;
	localparam int IRQ_CLEARED_BIT = 2;
	localparam int IRQ_UVLO_BIT    = 3;
	localparam int IRQ_WIDTH       = 4;
	// timing
	localparam int DIM_LOW_CYCLES    = 32750;
	localparam real CLK_MHZ          = 125.0;
	localparam real DITHER_RATE_KHZ  = 12.5;
	// triangle period in pclk cycles, rounded down
	localparam int DITHER_PERIOD_CYC =
		int'($floor(CLK_MHZ * 1000.0 / DITHER_RATE_KHZ));
	localparam int DITHER_HALF_CYC   = DITHER_PERIOD_CYC / 2;
	// dither scale: 0.95 .. 1.05 times, in per-mille
	localparam logic [10:0] DITHER_MIN_PM = 11'h3b6;
	localparam logic [10:0] DITHER_MAX_PM = 11'h41a;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_SHORT   = 3'b001,
		ST_RUN     = 3'b010,
		ST_LATCHED = 3'b011,
		ST_SHUT    = 3'b100
	} sup_state_e;
endpackage

// file: hw/fault_if.sv
`timescale 1ns/1ps
interface fault_if;
	logic latch_evt;
	logic frequency_set_pin_evt;
	logic clear_evt;
	logic uvlo_evt;
	modport src (output latch_evt, output frequency_set_pin_evt, output clear_evt,
		output uvlo_evt);
	modport dst (input latch_evt, input frequency_set_pin_evt, input clear_evt,
		input uvlo_evt);
endinterface

// file: hw/sync2.sv
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// file: hw/dither_gen.sv
`timescale 1ns/1ps
module dither_gen #(
	parameter int HALF = led_sup_pkg::DITHER_HALF_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	output logic      [10:0] scale_reg,
	output logic             dir_up_reg
);
	logic [15:0] step_reg;

	// triangle: scale climbs min..max then falls back, never pauses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_reg   <= '0;
			dir_up_reg <= 1'b1;
			scale_reg  <= led_sup_pkg::DITHER_MIN_PM;
		end else begin
			if (step_reg == 16'(HALF - 1)) begin
				step_reg   <= '0;
				dir_up_reg <= ~dir_up_reg;
			end else begin
				step_reg <= step_reg + 16'h0001;
			end
			// per-mille linear interpolation over one half period
			scale_reg <= dir_up_reg ?
				11'(led_sup_pkg::DITHER_MIN_PM +
					(32'(step_reg) * 32'd100) / HALF) :
				11'(led_sup_pkg::DITHER_MAX_PM -
					(32'(step_reg) * 32'd100) / HALF);
		end
	end

	dither_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		scale_reg >= led_sup_pkg::DITHER_MIN_PM &&
		scale_reg <= led_sup_pkg::DITHER_MAX_PM)
		else $error("dither scale out of range");
	dither_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
		(step_reg == 16'(HALF - 1)) |=> (dir_up_reg != $past(dir_up_reg)))
		else $error("triangle did not turn");
endmodule

// file: hw/led_supervisor.sv
`timescale 1ns/1ps
// What this block does
// - dither switching frequency between 0.95 and 1.05 of programmed value.
// - triangular sweep repeating at 12.5 kHz, symmetric up and down.
// - watch input, switch current, output, switch node and sink detectors.
// - startup masking, when selected, holds sinks off for one edge on entering run.
// - cycle limit ends on-time only; flag clear, switch and sinks on.
// - secondary switch limit latches everything off and asserts flag.
// - dimming low for 32750 cycles clears a latched fault.
// - input sense trip latches everything off and asserts flag.
// - switch node secondary overvoltage latches everything off, asserts flag.
// - current-set overcurrent stops boost and sinks, switch on, no flag.
// - frequency-set overcurrent shuts all off with flag, soft restart after.
// - output overvoltage stops switching only; sinks, switch on, no flag.
// - a fault is shown by driving the flag output low.
// - shutdown clears fault state and keeps sinks off until dimming high.
// - undervoltage lockout turns all off without flag, clears latches.
module led_supervisor #(
	parameter int NSINK    = 4,
	parameter int DIM_LOW  = led_sup_pkg::DIM_LOW_CYCLES,
	parameter int DITHER_H = led_sup_pkg::DITHER_HALF_CYC
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             dim_in,
	input  wire logic             uvlo_in,
	input  wire logic             cycle_current_limit,
	input  wire logic             secondary_switch_current_limit,
	input  wire logic             input_sense_trip_level,
	input  wire logic             switch_node_ovp,
	input  wire logic             overvoltage_threshold,
	input  wire logic             led_current_set_pin,
	input  wire logic             frequency_set_pin,
	input  wire logic [NSINK-1:0] led_sink_pin_short,
	input  wire logic [NSINK-1:0] led_sink_pin_unreg,
	output logic                  boost_en,
	output logic                  ontime_cut,
	output logic                  ovp_raise,
	output logic                  disconnect_on,
	output logic      [NSINK-1:0] sink_en,
	output logic                  fault_n,
	output logic      [10:0]      dither_scale,
	output logic                  irq
);
	// nine single detectors, then short and unregulated flags per sink
	localparam int NIN = 9 + 2 * NSINK;

	led_sup_pkg::sup_state_e state_reg, state_next;
	logic [NIN-1:0]   raw_s;
	logic             dim_s, uvlo_s, cyc_s, sec_s, vin_s, swn_s;
	logic             ovp_s, led_current_set_pin_s, frequency_set_pin_s;
	logic [NSINK-1:0] short_s, unreg_s;
	logic [15:0]      low_cnt_reg;
	logic             low_done;
	logic [NSINK-1:0] open_reg;
	logic             probe_reg;
	logic [31:0]      ctrl_reg;
	logic [led_sup_pkg::IRQ_WIDTH-1:0] int_stat_reg, int_en_reg, ev_vec;
	logic             dir_up;
	logic [10:0]      scale_w;
	logic             latch_trip, enable_sw, mask_startup;
	logic             apb_wr, apb_rd;
	fault_if          fev ();

	// all pin-side detectors pass two flops before use
	sync2 #(.WIDTH(NIN)) sync2_inst (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({dim_in, uvlo_in, cycle_current_limit,
			secondary_switch_current_limit, input_sense_trip_level,
			switch_node_ovp, overvoltage_threshold,
			led_current_set_pin, frequency_set_pin,
			led_sink_pin_short, led_sink_pin_unreg}),
		.q       (raw_s)
	);
	assign {dim_s, uvlo_s, cyc_s, sec_s, vin_s, swn_s, ovp_s,
		led_current_set_pin_s, frequency_set_pin_s} = raw_s[NIN-1:NIN-9];
	assign short_s = raw_s[2*NSINK-1:NSINK];
	assign unreg_s = raw_s[NSINK-1:0];

	dither_gen #(.HALF(DITHER_H)) dither_gen_inst (
		.pclk       (pclk),
		.presetn    (presetn),
		.scale_reg  (scale_w),
		.dir_up_reg (dir_up)
	);

	assign enable_sw    = ctrl_reg[led_sup_pkg::CTRL_ENABLE_BIT];
	assign mask_startup = ctrl_reg[led_sup_pkg::CTRL_MASK_BIT];
	// latching detectors are acted on only in the short and run states
	assign latch_trip = sec_s | vin_s | swn_s;
	assign low_done   = (low_cnt_reg == 16'(DIM_LOW - 1)) && !dim_s;

	// dimming low-time counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_reg <= '0;
		end else if (dim_s) begin
			low_cnt_reg <= '0;
		end else if (low_cnt_reg != 16'(DIM_LOW - 1)) begin
			low_cnt_reg <= low_cnt_reg + 16'h0001;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		led_sup_pkg::ST_OFF: begin
			// no restart while a frequency-set overload persists
			if (enable_sw && !uvlo_s && dim_s && !frequency_set_pin_s) begin
				state_next = led_sup_pkg::ST_SHORT;
			end
		end
		led_sup_pkg::ST_SHORT: begin
			if (latch_trip) begin
				state_next = led_sup_pkg::ST_LATCHED;
			end else if (short_s == '0) begin
				state_next = led_sup_pkg::ST_RUN;
			end
		end
		led_sup_pkg::ST_RUN: begin
			if (latch_trip) begin
				state_next = led_sup_pkg::ST_LATCHED;
			end else if (frequency_set_pin_s) begin
				state_next = led_sup_pkg::ST_OFF;
			end else if (!enable_sw || low_done) begin
				state_next = led_sup_pkg::ST_SHUT;
			end
		end
		led_sup_pkg::ST_LATCHED: begin
			// restart conditions are not looked at here
			if (low_done) begin
				state_next = led_sup_pkg::ST_SHUT;
			end
		end
		led_sup_pkg::ST_SHUT: begin
			if (dim_s) begin
				state_next = led_sup_pkg::ST_OFF;
			end
		end
		default: state_next = led_sup_pkg::ST_OFF;
		endcase
		// undervoltage overrides and clears any latch
		if (uvlo_s) begin
			state_next = led_sup_pkg::ST_OFF;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= led_sup_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// open-sink search: raise output, drop unregulated strings at ovp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_reg  <= '0;
			probe_reg <= 1'b0;
		end else if (state_reg != led_sup_pkg::ST_RUN) begin
			open_reg  <= '0;
			probe_reg <= 1'b0;
		end else if (!probe_reg && ((unreg_s & ~open_reg) != '0)) begin
			probe_reg <= 1'b1;
		end else if (probe_reg && ovp_s) begin
			open_reg  <= open_reg | unreg_s;
			probe_reg <= 1'b0;
		end
	end

	// outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_en      <= 1'b0;
			ontime_cut    <= 1'b0;
			ovp_raise     <= 1'b0;
			disconnect_on <= 1'b0;
			sink_en       <= '0;
			fault_n       <= 1'b1;
			dither_scale  <= led_sup_pkg::DITHER_MIN_PM;
		end else begin
			dither_scale  <= scale_w;
			ovp_raise     <= probe_reg;
			// on-time cut only; sinks and switch unaffected
			ontime_cut    <= cyc_s && state_next == led_sup_pkg::ST_RUN;
			disconnect_on <= state_next == led_sup_pkg::ST_SHORT ||
				state_next == led_sup_pkg::ST_RUN;
			// boost stops for ovp and current-set overload only
			boost_en <= state_next == led_sup_pkg::ST_RUN &&
				!led_current_set_pin_s && !(ovp_s && !probe_reg);
			sink_en <= (state_next == led_sup_pkg::ST_RUN && !led_current_set_pin_s &&
				!(mask_startup && state_reg != led_sup_pkg::ST_RUN)) ?
				~open_reg : '0;
			// low = fault: latch, or frequency-set overload
			fault_n <= !(state_next == led_sup_pkg::ST_LATCHED ||
				(frequency_set_pin_s && !uvlo_s &&
				state_next == led_sup_pkg::ST_OFF &&
				state_reg != led_sup_pkg::ST_SHUT));
		end
	end

	assign fev.latch_evt = state_next == led_sup_pkg::ST_LATCHED &&
		state_reg != led_sup_pkg::ST_LATCHED;
	assign fev.frequency_set_pin_evt  = frequency_set_pin_s && state_reg == led_sup_pkg::ST_RUN;
	assign fev.clear_evt = state_next == led_sup_pkg::ST_SHUT &&
		state_reg != led_sup_pkg::ST_SHUT;
	assign fev.uvlo_evt  = uvlo_s && state_reg != led_sup_pkg::ST_OFF;
	assign ev_vec = {fev.uvlo_evt, fev.clear_evt, fev.frequency_set_pin_evt,
		fev.latch_evt};

	// apb slave, zero wait states
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= led_sup_pkg::CTRL_RESET;
			int_en_reg   <= '0;
			int_stat_reg <= '0;
		end else begin
			if (apb_wr && paddr == led_sup_pkg::CTRL_OFFSET) begin
				ctrl_reg <= {30'h0, pwdata[1:0]};
			end
			if (apb_wr && paddr == led_sup_pkg::INT_EN_OFFSET) begin
				int_en_reg <= pwdata[led_sup_pkg::IRQ_WIDTH-1:0];
			end
			// new events win over a simultaneous clear
			if (apb_wr && paddr == led_sup_pkg::INT_CLEAR_OFFSET) begin
				int_stat_reg <= (int_stat_reg &
					~pwdata[led_sup_pkg::IRQ_WIDTH-1:0]) | ev_vec;
			end else begin
				int_stat_reg <= int_stat_reg | ev_vec;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq     <= 1'b0;
		end else begin
			irq    <= (int_stat_reg & int_en_reg) != '0;
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !(paddr inside {led_sup_pkg::CTRL_OFFSET,
					led_sup_pkg::STATUS_OFFSET,
					led_sup_pkg::INT_STAT_OFFSET,
					led_sup_pkg::INT_CLEAR_OFFSET,
					led_sup_pkg::INT_EN_OFFSET,
					led_sup_pkg::DITHER_OFFSET});
			end
			if (apb_rd) begin
				case (paddr)
				led_sup_pkg::CTRL_OFFSET:     prdata <= ctrl_reg;
				led_sup_pkg::STATUS_OFFSET:   prdata <= {20'h0, open_reg[3:0],
					1'b0, state_reg, !fault_n, sink_en != '0,
					disconnect_on, boost_en};
				led_sup_pkg::INT_STAT_OFFSET: prdata <= {28'h0, int_stat_reg};
				led_sup_pkg::INT_EN_OFFSET:   prdata <= {28'h0, int_en_reg};
				led_sup_pkg::DITHER_OFFSET:   prdata <= {20'h0, dir_up,
					dither_scale};
				default:                      prdata <= '0;
				endcase
			end
		end
	end

	latch_all_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == led_sup_pkg::ST_LATCHED && !low_done &&
		!uvlo_s) |=>
		(!boost_en && !disconnect_on && sink_en == '0 && !fault_n))
		else $error("latched state not all off");
	latch_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_trip && !uvlo_s && state_reg == led_sup_pkg::ST_RUN) |=>
		(state_reg == led_sup_pkg::ST_LATCHED))
		else $error("latch trip missed");
	uvlo_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		uvlo_s |=> (state_reg == led_sup_pkg::ST_OFF) ##0 fault_n)
		else $error("uvlo did not clear");
	low_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		dim_s |=> (low_cnt_reg == 16'h0000))
		else $error("low counter not restarted");
	sequence latched_low_s;
		state_reg == led_sup_pkg::ST_LATCHED && low_done && !uvlo_s;
	endsequence
	latch_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		latched_low_s |=> state_reg == led_sup_pkg::ST_SHUT)
		else $error("latch not released");
	shut_sinks_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == led_sup_pkg::ST_SHUT) |=> (sink_en == '0))
		else $error("sinks on in shutdown");
	short_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == led_sup_pkg::ST_SHORT && short_s != '0 &&
		!latch_trip && !uvlo_s) |=>
		(disconnect_on && !boost_en && fault_n))
		else $error("short hold wrong");
	led_current_set_pin_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(led_current_set_pin_s && state_next == led_sup_pkg::ST_RUN) |=>
		(!boost_en && sink_en == '0 && disconnect_on && fault_n))
		else $error("current-set response wrong");
	ovp_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovp_s && !probe_reg && state_next == led_sup_pkg::ST_RUN) |=>
		(!boost_en && disconnect_on && fault_n))
		else $error("ovp response wrong");
	// outputs follow the decided state one edge later
	frequency_set_pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == led_sup_pkg::ST_OFF && frequency_set_pin_s && !uvlo_s) |=>
		(state_reg == led_sup_pkg::ST_OFF && !fault_n && !disconnect_on))
		else $error("frequency-set hold wrong");
	cycle_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cyc_s && state_next == led_sup_pkg::ST_RUN) |=>
		(ontime_cut && disconnect_on && fault_n))
		else $error("cycle limit response wrong");
	latch_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_trip && !uvlo_s && state_reg == led_sup_pkg::ST_RUN) |=>
		(!fault_n && !boost_en && !disconnect_on && sink_en == '0))
		else $error("latch trip outputs wrong");
	low_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!dim_s && low_cnt_reg != 16'(DIM_LOW - 1)) |=>
		(low_cnt_reg == $past(low_cnt_reg) + 16'h0001))
		else $error("low counter did not step");
	sequence probe_hit_s;
		probe_reg && ovp_s && state_reg == led_sup_pkg::ST_RUN;
	endsequence
	open_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		probe_hit_s |=> (!probe_reg &&
		(open_reg & $past(unreg_s)) == $past(unreg_s)))
		else $error("open sink not dropped");
endmodule

// file: sim/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
	input  wire logic       pclk,
	input  wire logic       ovp_raise,
	input  wire logic [3:0] sink_en,
	input  wire logic [3:0] open_mask,
	input  wire logic       ovp_in,
	output logic            overvoltage_threshold,
	output logic      [3:0] led_sink_pin_unreg
);
	logic [1:0] climb_reg;

	// vout takes a few cycles to climb to the trip point
	always_ff @(posedge pclk) begin
		if (!ovp_raise)
			climb_reg <= 2'h0;
		else if (climb_reg != 2'h3)
			climb_reg <= climb_reg + 2'h1;
	end
	assign overvoltage_threshold = ovp_in | (climb_reg == 2'h3);
	// an open string never reaches regulation while its sink is on
	assign led_sink_pin_unreg = open_mask & sink_en;
endmodule

// file: sim/tb_led_supervisor.sv
`timescale 1ns/1ps
module tb_led_supervisor;
	localparam int DL = 20;
	localparam int DH = 10;
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h0;
	logic        dim_in    = 1'b0;
	logic        uvlo_in   = 1'b0;
	logic [6:0]  det       = 7'h00;
	logic [3:0]  shorts    = 4'h0;
	logic [3:0]  open_mask = 4'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, ovp_th, boost_en, ontime_cut, ovp_raise;
	logic        disconnect_on, fault_n, irq, e;
	logic [3:0]  unreg, sink_en;
	logic [10:0] dither_scale, lo, hi, prev;
	logic [31:0] r;
	logic [6:0]  trip [3] = '{7'h20, 7'h10, 7'h08};
	int          n_errors, total_checks, cycles, last, per;

	led_supervisor #(.NSINK(4), .DIM_LOW(DL), .DITHER_H(DH))
	led_supervisor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dim_in(dim_in), .uvlo_in(uvlo_in),
		.cycle_current_limit(det[6]),
		.secondary_switch_current_limit(det[5]),
		.input_sense_trip_level(det[4]), .switch_node_ovp(det[3]),
		.overvoltage_threshold(ovp_th), .led_current_set_pin(det[1]),
		.frequency_set_pin(det[0]), .led_sink_pin_short(shorts),
		.led_sink_pin_unreg(unreg), .boost_en(boost_en),
		.ontime_cut(ontime_cut), .ovp_raise(ovp_raise),
		.disconnect_on(disconnect_on), .sink_en(sink_en),
		.fault_n(fault_n), .dither_scale(dither_scale), .irq(irq));

	power_stage_model power_stage_model_inst (.pclk(pclk),
		.ovp_raise(ovp_raise), .sink_en(sink_en), .open_mask(open_mask),
		.ovp_in(det[2]), .overvoltage_threshold(ovp_th),
		.led_sink_pin_unreg(unreg));

	always #4 pclk = ~pclk;

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	// packed as boost, disconnect, sinks, flag
	task automatic outs(input logic [6:0] exp);
		check({25'h0, boost_en, disconnect_on, sink_en, fault_n},
			{25'h0, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		if (n >= 20)
			n_errors++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(r, exp);
	endtask

	initial begin
		cyc(4);
		presetn <= 1'b1;
		cyc(2);
		outs(7'h01);
		rd(led_sup_pkg::CTRL_OFFSET, led_sup_pkg::CTRL_RESET);
		xfer(1'b0, 12'h0fc, 32'h0);
		check({31'h0, e}, 32'h1);
		lo = 11'h7ff;
		hi = 11'h000;
		prev = 11'h000;
		last = -1;
		for (int i = 0; i < 6 * DH; i++) begin
			@(posedge pclk);
			if (dither_scale < lo)
				lo = dither_scale;
			if (dither_scale > hi)
				hi = dither_scale;
			if (dither_scale == led_sup_pkg::DITHER_MAX_PM &&
				prev != led_sup_pkg::DITHER_MAX_PM) begin
				if (last >= 0)
					per = i - last;
				last = i;
			end
			prev = dither_scale;
		end
		check(lo, led_sup_pkg::DITHER_MIN_PM);
		check(hi, led_sup_pkg::DITHER_MAX_PM);
		check(per, 2 * DH);
		$display("test reset and dither done");
		shorts <= 4'h2;
		dim_in <= 1'b1;
		cyc(10);
		outs(7'h21);
		shorts <= 4'h0;
		cyc(12);
		outs(7'h7f);
		det <= 7'h40;
		cyc(6);
		check(ontime_cut, 1'b1);
		outs(7'h7f);
		det <= 7'h04;
		cyc(6);
		outs(7'h3f);
		det <= 7'h02;
		cyc(6);
		outs(7'h21);
		det <= 7'h00;
		cyc(8);
		outs(7'h7f);
		open_mask <= 4'h4;
		cyc(40);
		outs(7'h77);
		check(ovp_raise, 1'b0);
		open_mask <= 4'h0;
		$display("test auto-restart faults done");
		xfer(1'b1, led_sup_pkg::INT_EN_OFFSET, 32'h7);
		xfer(1'b1, led_sup_pkg::INT_CLEAR_OFFSET, 32'hf);
		foreach (trip[k]) begin
			det <= trip[k];
			cyc(6);
			outs(7'h00);
			check(irq, 1'b1);
			rd(led_sup_pkg::STATUS_OFFSET, 32'h38);
			det <= 7'h00;
			dim_in <= 1'b0;
			cyc(DL - 2);
			dim_in <= 1'b1;
			cyc(8);
			outs(7'h00);
			dim_in <= 1'b0;
			cyc(DL + 6);
			check(sink_en, 4'h0);
			check(fault_n, 1'b1);
			rd(led_sup_pkg::INT_STAT_OFFSET, 32'h5);
			xfer(1'b1, led_sup_pkg::INT_CLEAR_OFFSET, 32'hf);
			cyc(2);
			check(irq, 1'b0);
			dim_in <= 1'b1;
			cyc(14);
			outs(7'h7f);
		end
		$display("test latched faults done");
		det <= 7'h20;
		cyc(6);
		det <= 7'h00;
		uvlo_in <= 1'b1;
		cyc(6);
		outs(7'h01);
		// the uvlo event is left masked, so irq must drop
		xfer(1'b1, led_sup_pkg::INT_CLEAR_OFFSET, 32'h1);
		rd(led_sup_pkg::INT_STAT_OFFSET, 32'h8);
		check(irq, 1'b0);
		uvlo_in <= 1'b0;
		cyc(14);
		outs(7'h7f);
		det <= 7'h01;
		cyc(6);
		outs(7'h00);
		rd(led_sup_pkg::INT_STAT_OFFSET, 32'ha);
		det <= 7'h00;
		cyc(14);
		outs(7'h7f);
		$display("test uvlo and frequency-set done");
		xfer(1'b1, led_sup_pkg::CTRL_OFFSET, 32'h0);
		cyc(4);
		outs(7'h01);
		rd(led_sup_pkg::INT_STAT_OFFSET, 32'he);
		xfer(1'b1, led_sup_pkg::CTRL_OFFSET, 32'h1);
		rd(led_sup_pkg::CTRL_OFFSET, 32'h1);
		cyc(10);
		outs(7'h7f);
		$display("test control done");
		conclude();
	end
endmodule
